// file: design/sucm_config.sv
// Prescaler, channel mode registers, start arming and interrupt pulses of the serial unit.
//
// Notes on behaviour
// - A 16-bit prescaler register; bits 3 to 0 pick one shared operation clock.
// - With the PLL, operation clock is peripheral clock over two to the power of the code.
// - Codes 3 to 15 keep their frequency whether or not the PLL is used.
// - Reset clears the prescaler to zero, giving the undivided peripheral clock.
// - Prescaler accepts a full 16-bit write or a write of the low byte alone.
// - Reset loads each channel mode register with 0020h.
// - Mode registers are locked while the channel runs, except the interrupt-source bit.
// - Channel 1 start trigger: 0 is software only, 1 is receive pin edge.
// - A transfer begins only after the start bit is set and the trigger follows.
// - Invert bit 0 starts on falling edge, data as is; 1 rising, inverted.
// - Interrupt source bit 0 means transfer end, 1 means buffer empty.
// - Mode registers take only whole 16-bit writes.
// - With the unit clock disabled, the unit is held in reset and ignores writes.
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/10ps
module sucm_config
  import sucm_pkg::*;
#(
  parameter int AW = 22
)
(
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [AW-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Peripheral clock source and receive pin.
  input wire logic clk_src_pll_i,
  input wire logic receive_input_pin_i,
  // Events from the channel datapaths.
  input wire logic [NCH-1:0] xfer_end_i,
  input wire logic [NCH-1:0] buf_empty_i,
  // Outputs to the channel datapaths.
  output logic shared_operation_clock_o,
  output logic unit_reset_o,
  output logic [NCH-1:0] channel_run_flag_o,
  output logic [NCH-1:0] xfer_start_o,
  output sucm_mode_t [NCH-1:0] mode_o,
  output logic [NCH-1:0] irq_o
);

  logic unit_clock_enable_r;
  logic [15:0] presc_r;
  logic [15:0] mode_r [NCH];
  logic [NCH-1:0] run_r;
  logic [NCH-1:0] armed_r;
  logic [NCH-1:0] pend_r;
  logic [DIV_W-1:0] div_cnt_r;
  logic rx_prev_r;
  logic req;
  logic wr;
  logic [IDX_W-1:0] idx;
  logic [31:0] rd_nxt;
  logic [DIV_W-1:0] div_mask;
  logic [NCH-1:0] trig;

  function automatic logic [3:0] div_exp(input logic [3:0] code, input logic pll);
    logic [3:0] e;
    e = CODE_ZERO;
    if (pll)
    begin
      e = code;
    end
    else if (code > NONPLL_SHIFT)
    begin
      e = code - NONPLL_SHIFT;
    end
    return e;
  endfunction

  function automatic logic [15:0] mode_wmask(input int ch);
    return (ch == 0) ? MODE0_WMASK : MODE1_WMASK;
  endfunction

  assign req = cyc_i && stb_i;
  // A write takes effect at the edge where the master samples ack high.
  assign wr = req && we_i && ack_o;
  assign idx = adr_i[IDX_W+1:2];

  // Bus answer: one wait state, ack for one cycle.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
    end
    else
    begin
      ack_o <= req && !ack_o;
    end
  end

  always_comb
  begin
    rd_nxt = DAT_ZERO;
    if (idx == IDX_MODE0)
    begin
      rd_nxt[15:0] = mode_r[0];
    end
    else if (idx == IDX_MODE1)
    begin
      rd_nxt[15:0] = mode_r[1];
    end
    else if (idx == IDX_PRESC)
    begin
      rd_nxt[15:0] = presc_r;
    end
    else if (idx == IDX_CTRL)
    begin
      rd_nxt[CTRL_EN_BIT] = unit_clock_enable_r;
    end
    else if (idx == IDX_RUN)
    begin
      rd_nxt[NCH-1:0] = run_r;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      dat_o <= DAT_ZERO;
    end
    else if (req && !ack_o && !we_i)
    begin
      dat_o <= rd_nxt;
    end
  end

  // Unit clock enable; this register itself is never gated.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      unit_clock_enable_r <= 1'b0;
    end
    else if (wr && idx == IDX_CTRL && sel_i[0])
    begin
      unit_clock_enable_r <= dat_i[CTRL_EN_BIT];
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      unit_reset_o <= 1'b1;
    end
    else
    begin
      unit_reset_o <= !unit_clock_enable_r;
    end
  end

  // Prescaler: only the code field is stored, upper bits read as zero.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || !unit_clock_enable_r)
    begin
      presc_r <= PRESC_RST;
    end
    else if (wr && idx == IDX_PRESC && sel_i[0])
    begin
      presc_r[CODE_W-1:0] <= dat_i[CODE_W-1:0];
    end
  end

  // Mode registers: whole halfword writes only, locked while running except the md bit.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || !unit_clock_enable_r)
    begin
      for (int n = 0; n < NCH; n++)
      begin
        mode_r[n] <= MODE_RST;
      end
    end
    else
    begin
      for (int n = 0; n < NCH; n++)
      begin
        if (wr && idx == ((n == 0) ? IDX_MODE0 : IDX_MODE1) && sel_i[1:0] == 2'b11)
        begin
          if (run_r[n])
          begin
            mode_r[n] <= (mode_r[n] & ~MODE_MD_MASK) | (dat_i[15:0] & MODE_MD_MASK);
          end
          else
          begin
            mode_r[n] <= dat_i[15:0] & mode_wmask(n);
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    for (int n = 0; n < NCH; n++)
    begin
      if (rst_i)
      begin
        mode_o[n] <= '0;
      end
      else
      begin
        mode_o[n].sts <= mode_r[n][STS_BIT];
        mode_o[n].sis <= mode_r[n][SIS_BIT];
        mode_o[n].md <= mode_r[n][MD_BIT];
      end
    end
  end

  // Shared operation clock as a one-cycle tick every 2**exp peripheral clocks.
  assign div_mask = (DIV_ONE << div_exp(presc_r[CODE_W-1:0], clk_src_pll_i)) - DIV_ONE;

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || !unit_clock_enable_r)
    begin
      div_cnt_r <= DIV_ZERO;
      shared_operation_clock_o <= 1'b0;
    end
    else
    begin
      div_cnt_r <= div_cnt_r + DIV_ONE;
      shared_operation_clock_o <= (div_cnt_r & div_mask) == div_mask;
    end
  end

  // Start trigger: channel 0 is software only; channel 1 may wait for a pin edge.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      rx_prev_r <= 1'b1;
    end
    else
    begin
      rx_prev_r <= receive_input_pin_i;
    end
  end

  always_comb
  begin
    trig[0] = 1'b1;
    trig[1] = 1'b1;
    if (mode_r[1][STS_BIT])
    begin
      if (mode_r[1][SIS_BIT])
      begin
        trig[1] = receive_input_pin_i && !rx_prev_r;
      end
      else
      begin
        trig[1] = !receive_input_pin_i && rx_prev_r;
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || !unit_clock_enable_r)
    begin
      run_r <= '0;
      armed_r <= '0;
      xfer_start_o <= '0;
    end
    else
    begin
      for (int n = 0; n < NCH; n++)
      begin
        xfer_start_o[n] <= armed_r[n] && trig[n];
        if (wr && idx == IDX_STOP && sel_i[0] && dat_i[n])
        begin
          run_r[n] <= 1'b0;
          armed_r[n] <= 1'b0;
        end
        else if (wr && idx == IDX_START && sel_i[0] && dat_i[n])
        begin
          run_r[n] <= 1'b1;
          armed_r[n] <= 1'b1;
        end
        else if (armed_r[n] && trig[n])
        begin
          armed_r[n] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      channel_run_flag_o <= '0;
    end
    else
    begin
      channel_run_flag_o <= run_r;
    end
  end

  // Interrupt events wait for the next tick; a new event beats the clear.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || !unit_clock_enable_r)
    begin
      pend_r <= '0;
      irq_o <= '0;
    end
    else
    begin
      for (int n = 0; n < NCH; n++)
      begin
        pend_r[n] <= (mode_r[n][MD_BIT] ? buf_empty_i[n] : xfer_end_i[n])
                     || (pend_r[n] && !shared_operation_clock_o);
        irq_o[n] <= pend_r[n] && shared_operation_clock_o;
      end
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_presc_held_off: assert property (!unit_clock_enable_r |=> presc_r == PRESC_RST)
    else $error("prescaler not held while unit disabled");
  a_presc_low_write: assert property (wr && idx == IDX_PRESC && sel_i[0] && unit_clock_enable_r
    |=> presc_r[CODE_W-1:0] == $past(dat_i[CODE_W-1:0]) && presc_r[15:CODE_W] == '0)
    else $error("prescaler write lost");
  a_mode_locked: assert property (run_r[1] && unit_clock_enable_r
    |=> (mode_r[1] & ~MODE_MD_MASK) == $past(mode_r[1] & ~MODE_MD_MASK))
    else $error("mode changed while running");
  a_mode_md_live: assert property (run_r[0] && wr && idx == IDX_MODE0 && sel_i == 4'hf
    |=> mode_r[0][MD_BIT] == $past(dat_i[MD_BIT]))
    else $error("interrupt source not updated while running");
  a_mode_halfword: assert property (wr && idx == IDX_MODE0 && sel_i[1:0] != 2'b11
    |=> $stable(mode_r[0]))
    else $error("partial mode write accepted");
  a_start_armed: assert property (xfer_start_o[1] |-> $past(armed_r[1]))
    else $error("start without arming");
  a_ch0_start: assert property (wr && idx == IDX_START && sel_i[0] && dat_i[0]
    && unit_clock_enable_r |=> ##1 xfer_start_o[0])
    else $error("software start not issued");
  a_tick_code0: assert property (unit_clock_enable_r && presc_r == PRESC_RST
    && $past(unit_clock_enable_r) && $past(presc_r == PRESC_RST) |=> shared_operation_clock_o)
    else $error("code zero must tick every cycle");
  a_irq_pulse: assert property (irq_o[0] |=> !irq_o[0])
    else $error("interrupt longer than one cycle");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held two cycles");

  c_pin_start: cover property (mode_r[1][STS_BIT] && armed_r[1] ##[1:20] xfer_start_o[1]);
  c_irq_empty: cover property (mode_r[0][MD_BIT] && irq_o[0]);
  c_divided_tick: cover property (presc_r[CODE_W-1:0] == 4'h4 && shared_operation_clock_o);
endmodule

// file: design/sucm_pkg.sv
// Package with the register map, field layout and types of the serial clock and mode block.
package sucm_pkg;
  // Register offsets are kept as word indices; the byte address is four times the index.
  localparam int unsigned IDX_W = 20;
  localparam logic [19:0] IDX_MODE0 = 20'hf0590;
  localparam logic [19:0] IDX_MODE1 = 20'hf0592;
  localparam logic [19:0] IDX_PRESC = 20'hf05a6;
  localparam logic [19:0] IDX_CTRL = 20'hf05b0;
  localparam logic [19:0] IDX_START = 20'hf05b2;
  localparam logic [19:0] IDX_STOP = 20'hf05b4;
  localparam logic [19:0] IDX_RUN = 20'hf05b6;
  // Reset values and writable bits.
  localparam logic [15:0] MODE_RST = 16'h0020;
  localparam logic [15:0] PRESC_RST = 16'h0000;
  localparam logic [15:0] MODE0_WMASK = 16'h0023;
  localparam logic [15:0] MODE1_WMASK = 16'h0163;
  localparam logic [15:0] MODE_MD_MASK = 16'h0001;
  localparam int MD_BIT = 0;
  localparam int SIS_BIT = 6;
  localparam int STS_BIT = 8;
  localparam int CTRL_EN_BIT = 0;
  localparam int CODE_W = 4;
  localparam int DIV_W = 15;
  localparam int NCH = 2;
  // Without the PLL the peripheral clock is eight times slower, so three fewer halvings.
  localparam logic [3:0] NONPLL_SHIFT = 4'h3;
  localparam logic [3:0] CODE_ZERO = 4'h0;
  localparam logic [DIV_W-1:0] DIV_ONE = 15'h0001;
  localparam logic [DIV_W-1:0] DIV_ZERO = 15'h0000;
  localparam logic [31:0] DAT_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic sts;
    logic sis;
    logic md;
  } sucm_mode_t;
endpackage

// file: sim/sucm_config_test.sv
// Self-checking bench for the serial clock and mode configuration block.
`timescale 1ns/10ps
module sucm_config_test;
  import sucm_pkg::*;
  logic sys_clk_i;
  logic rst_i;
  logic cyc, stb, we, pin, pll, ack, tick, ureset;
  logic [21:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, dat_o, q;
  logic [1:0] xend, bemp, run, xst, irq;
  sucm_mode_t [1:0] mode;
  int err_count;
  int samples_checked;
  int st_cnt[2];
  int irq_cnt[2];

  sucm_config #(.AW(22)) uut (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc),
    .stb_i(stb),
    .we_i(we),
    .adr_i(adr),
    .sel_i(sel),
    .dat_i(dat),
    .dat_o(dat_o),
    .ack_o(ack),
    .clk_src_pll_i(pll),
    .receive_input_pin_i(pin),
    .xfer_end_i(xend),
    .buf_empty_i(bemp),
    .shared_operation_clock_o(tick),
    .unit_reset_o(ureset),
    .channel_run_flag_o(run),
    .xfer_start_o(xst),
    .mode_o(mode),
    .irq_o(irq)
  );

  initial
  begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  // Pulse counters; a pulse held too long shows up as an extra count.
  always @(posedge sys_clk_i)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (xst[i] === 1'b1) st_cnt[i]++;
      if (irq[i] === 1'b1) irq_cnt[i]++;
    end
  end

  task finish_test;
    if (err_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  task wb(input logic w, input logic [19:0] ix, input logic [3:0] s, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {ix, 2'h0};
    sel <= s;
    dat <= d;
    @(posedge sys_clk_i);
    while (ack !== 1'b1 && n < 20)
    begin
      @(posedge sys_clk_i);
      n++;
    end
    if (n >= 20)
    begin
      err_count++;
      finish_test();
    end
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task rdc(input string nm, input logic [19:0] ix, input logic [31:0] e);
    wb(1'b0, ix, 4'hf, 32'h0);
    chk(nm, q, e);
  endtask

  // Lets a new setting reach the tick, syncs to one tick, then counts the cycles to the next one.
  task per(input logic [31:0] e);
    int n;
    n = 0;
    repeat (2) @(posedge sys_clk_i);
    while (tick !== 1'b1 && n < 100)
    begin
      @(posedge sys_clk_i);
      n++;
    end
    n = 1;
    @(posedge sys_clk_i);
    while (tick !== 1'b1 && n < 100)
    begin
      @(posedge sys_clk_i);
      n++;
    end
    if (n >= 100)
    begin
      err_count++;
      finish_test();
    end
    chk("tick period", 32'(n), e);
  endtask

  task setpin(input logic v);
    @(posedge sys_clk_i);
    pin <= v;
    repeat (4) @(posedge sys_clk_i);
  endtask

  initial
  begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 22'h0;
    sel = 4'h0;
    dat = 32'h0;
    pin = 1'b1;
    pll = 1'b1;
    xend = 2'h0;
    bemp = 2'h0;
    err_count = 0;
    samples_checked = 0;
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rdc("mode0", IDX_MODE0, 32'(MODE_RST));
    rdc("mode1", IDX_MODE1, 32'(MODE_RST));
    wb(1'b1, IDX_PRESC, 4'hf, 32'h5);
    rdc("presc off", IDX_PRESC, 32'(PRESC_RST));
    chk("unit reset", 32'(ureset), 32'h1);
    wb(1'b1, IDX_CTRL, 4'h1, 32'h1);
    repeat (4) @(posedge sys_clk_i);
    chk("unit reset", 32'(ureset), 32'h0);
    rdc("presc", IDX_PRESC, 32'(PRESC_RST));
    per(32'h1);
    wb(1'b1, IDX_PRESC, 4'h3, 32'ha);
    rdc("presc", IDX_PRESC, 32'ha);
    wb(1'b1, IDX_PRESC, 4'h1, 32'h2);
    rdc("presc", IDX_PRESC, 32'h2);
    wb(1'b1, IDX_PRESC, 4'h2, 32'h5);
    rdc("presc", IDX_PRESC, 32'h2);
    per(32'h4);
    wb(1'b1, IDX_PRESC, 4'h3, 32'h5);
    per(32'h20);
    wb(1'b1, IDX_STOP, 4'h1, 32'h3);
    @(posedge sys_clk_i);
    pll <= 1'b0;
    per(32'h4);
    wb(1'b1, IDX_PRESC, 4'h3, 32'h2);
    per(32'h1);
    @(posedge sys_clk_i);
    pll <= 1'b1;
    per(32'h4);
    wb(1'b1, 20'h00010, 4'hf, 32'hffff);
    rdc("unmapped", 20'h00010, 32'h0);
    wb(1'b1, IDX_MODE0, 4'h1, 32'h23);
    rdc("mode0 byte", IDX_MODE0, 32'(MODE_RST));
    wb(1'b1, IDX_MODE0, 4'h3, 32'h23);
    rdc("mode0", IDX_MODE0, 32'h23);
    wb(1'b1, IDX_MODE1, 4'h3, 32'h162);
    rdc("mode1", IDX_MODE1, 32'h162);
    @(posedge sys_clk_i);
    chk("mode0 out", 32'(mode[0]), 32'h1);
    chk("mode1 out", 32'(mode[1]), 32'h6);
    setpin(1'b0);
    setpin(1'b1);
    chk("start1 idle", 32'(st_cnt[1]), 32'h0);
    wb(1'b1, IDX_START, 4'h1, 32'h1);
    repeat (4) @(posedge sys_clk_i);
    chk("start0", 32'(st_cnt[0]), 32'h1);
    rdc("run", IDX_RUN, 32'h1);
    chk("run out", 32'(run), 32'h1);
    wb(1'b1, IDX_START, 4'h1, 32'h2);
    repeat (4) @(posedge sys_clk_i);
    chk("start1 armed", 32'(st_cnt[1]), 32'h0);
    setpin(1'b0);
    chk("start1 fall", 32'(st_cnt[1]), 32'h0);
    setpin(1'b1);
    chk("start1 rise", 32'(st_cnt[1]), 32'h1);
    wb(1'b1, IDX_MODE1, 4'h3, 32'h23);
    rdc("mode1 run", IDX_MODE1, 32'h163);
    // Channel 0 moves to transfer-end interrupts while it runs; channel 1 keeps buffer empty.
    wb(1'b1, IDX_MODE0, 4'hf, 32'h22);
    rdc("mode0 run", IDX_MODE0, 32'h22);
    @(posedge sys_clk_i);
    xend <= 2'h3;
    @(posedge sys_clk_i);
    xend <= 2'h0;
    repeat (12) @(posedge sys_clk_i);
    chk("irq0 end", 32'(irq_cnt[0]), 32'h1);
    chk("irq1 end", 32'(irq_cnt[1]), 32'h0);
    @(posedge sys_clk_i);
    bemp <= 2'h3;
    @(posedge sys_clk_i);
    bemp <= 2'h0;
    repeat (12) @(posedge sys_clk_i);
    chk("irq0 empty", 32'(irq_cnt[0]), 32'h1);
    chk("irq1 empty", 32'(irq_cnt[1]), 32'h1);
    wb(1'b1, IDX_STOP, 4'h1, 32'h3);
    rdc("run stop", IDX_RUN, 32'h0);
    chk("run out stop", 32'(run), 32'h0);
    // Channel 1 with pin trigger and plain polarity starts on a falling edge.
    wb(1'b1, IDX_MODE1, 4'h3, 32'h122);
    wb(1'b1, IDX_START, 4'h1, 32'h2);
    setpin(1'b0);
    chk("start1 falling", 32'(st_cnt[1]), 32'h2);
    finish_test();
  end
endmodule
